// >>> verification/dmar_rx_model.sv
// Behavioural receive FIFO of channel A that feeds the control block.
module dmar_rx_model (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_push,
   input wire i_pop,
   input wire [2:0] i_err,
   output reg o_start_bit,
   output wire o_rx_ready,
   output wire o_fifo_full,
   output wire [2:0] o_top_err
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [2:0] mem [0:3];
   reg [2:0] cnt;
   reg [2:0] err_q;
   // The start bit shows a cycle before the character lands, so a full
   // FIFO is still seen full when the start bit arrives.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt <= 3'h0;
         o_start_bit <= 1'b0;
         err_q <= 3'h0;
      end else begin
         o_start_bit <= i_push;
         err_q <= i_err;
         if (i_pop && cnt != 3'h0) begin
            mem[0] <= mem[1];
            mem[1] <= mem[2];
            mem[2] <= mem[3];
            cnt <= cnt - 3'h1;
         end else if (o_start_bit && cnt != 3'h4) begin
            mem[cnt[1:0]] <= err_q;
            cnt <= cnt + 3'h1;
         end
      end
   end
   // An empty FIFO shows all ones, so stale flags cannot pass as zero.
   assign o_rx_ready = cnt != 3'h0;
   assign o_fifo_full = cnt == 3'h4;
   assign o_top_err = o_rx_ready ? mem[0] : 3'h7;
endmodule

// >>> verification/dmar_top_props.sv
// Concurrent checks on the ports of the channel control block.
module dmar_top_props (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_cs_n,
   input wire i_rd_n,
   input wire i_wr_n,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_a_rx_ready,
   input wire [2:0] i_a_top_err,
   input wire [7:0] o_rdata,
   input wire o_irq_n,
   input wire [7:0] o_op_pins,
   input wire o_baud_set2,
   input wire [15:0] o_timer_preload,
   input wire [1:0] o_a_parity_mode,
   input wire o_a_parity_on,
   input wire o_a_multidrop,
   input wire o_a_parity_sense
);
   timeunit 1ns;
   timeprecision 100ps;
   reg prev_act;
   wire wr_tk;
   wire rd_tk;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // A held strobe is one access, so only its first edge opens a check.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prev_act <= 1'b0;
      end else begin
         prev_act <= !i_cs_n && (!i_rd_n || !i_wr_n);
      end
   end
   assign wr_tk = !i_cs_n && !i_wr_n && !prev_act;
   assign rd_tk = !i_cs_n && !i_rd_n && !prev_act;
   // Pins 3:2 have no alternate use, so they show the latch alone.
   pin_set_a: assert property (wr_tk && i_addr == 4'hE
      |-> ##2 (o_op_pins[3:2] & $past(i_wdata[3:2], 2)) == 2'h0)
      else $error("set strobe left a pin high");
   pin_clear_a: assert property (wr_tk && i_addr == 4'hF
      |-> ##2 (~o_op_pins[3:2] & $past(i_wdata[3:2], 2)) == 2'h0)
      else $error("clear strobe left a pin low");
   baud_select_a: assert property (wr_tk && i_addr == 4'h4
      |-> ##2 o_baud_set2 == $past(i_wdata[7], 2))
      else $error("baud set select wrong");
   preload_upper_a: assert property (wr_tk && i_addr == 4'h6
      |-> ##2 o_timer_preload[15:8] == $past(i_wdata, 2))
      else $error("preload upper byte wrong");
   parity_flags_a: assert property (1'b1
      |-> o_a_multidrop == (o_a_parity_mode == 2'h3)
      && o_a_parity_on == !o_a_parity_mode[1])
      else $error("parity flags disagree with mode");
   sense_mask_a: assert property (o_a_parity_mode == 2'h2
      |-> !o_a_parity_sense) else $error("parity sense with no parity");
   irq_masked_a: assert property (wr_tk && i_addr == 4'h5
      && i_wdata == 8'h00 |-> ##2 o_irq_n [*2])
      else $error("interrupt with all masks clear");
   err_top_a: assert property (rd_tk && i_addr == 4'h1
      && i_a_rx_ready |=> (o_rdata[7:5] & $past(i_a_top_err))
      == $past(i_a_top_err)) else $error("top character error lost");
   cover property (wr_tk && i_addr == 4'hE);
   cover property (rd_tk && i_addr == 4'h1 && i_a_rx_ready);
   cover property ($fell(o_irq_n));
endmodule
bind dmar_top dmar_top_props dmar_top_props_inst (.i_clk, .i_sys_rst,
   .i_cs_n, .i_rd_n, .i_wr_n, .i_addr, .i_wdata, .i_a_rx_ready,
   .i_a_top_err, .o_rdata, .o_irq_n, .o_op_pins, .o_baud_set2,
   .o_timer_preload, .o_a_parity_mode, .o_a_parity_on, .o_a_multidrop,
   .o_a_parity_sense);

// >>> verification/dmar_top_tb_top.sv
// Self-checking bench for the channel control block over its bus.
module dmar_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   reg i_clk = 1'b0, i_sys_rst = 1'b1;
   reg i_cs_n = 1'b1, i_rd_n = 1'b1, i_wr_n = 1'b1, push = 1'b0, pop = 1'b0;
   reg [3:0] i_addr = 4'h0;
   reg [7:0] i_wdata = 8'h00;
   reg [15:0] misc = 16'h0000;
   reg [2:0] perr = 3'h0;
   wire [2:0] i_a_top_err;
   wire i_a_rx_ready, i_a_fifo_full, i_a_start_bit, o_irq_n, o_baud_set2;
   wire o_a_parity_on, o_a_multidrop, o_a_parity_sense;
   wire o_b_parity_on, o_b_multidrop, o_b_parity_sense;
   wire [1:0] o_a_parity_mode, o_b_parity_mode;
   wire [7:0] o_rdata, o_op_pins;
   wire [15:0] o_timer_preload;
   int error_cnt = 0, checks_done = 0, i;
   int src[6] = '{10, 7, 11, 12, 14, 0};
   int bn[6] = '{0, 3, 4, 5, 6, 7};
   always #5 i_clk = ~i_clk;
   dmar_rx_model dmar_rx_model_inst (.i_clk, .i_sys_rst, .i_push(push),
      .i_pop(pop), .i_err(perr), .o_start_bit(i_a_start_bit),
      .o_rx_ready(i_a_rx_ready), .o_fifo_full(i_a_fifo_full),
      .o_top_err(i_a_top_err));
   // Spare status inputs come from one vector so each can be exercised; A break change and B start bit, error and overrun are tied low.
   dmar_top dmar_top_inst (.i_clk, .i_sys_rst, .i_cs_n, .i_rd_n, .i_wr_n,
      .i_addr, .i_wdata, .i_ip(misc[6:0]), .i_counter_ready(misc[7]),
      .i_a_rx_ready, .i_a_fifo_full, .i_a_start_bit, .i_a_top_err,
      .i_a_overrun(misc[8]), .i_a_tx_empty(misc[9]),
      .i_a_tx_ready(misc[10]), .i_a_break_change(1'b0),
      .i_b_rx_ready(misc[12]), .i_b_fifo_full(misc[13]),
      .i_b_start_bit(1'b0), .i_b_top_err(3'h0), .i_b_overrun(1'b0),
      .i_b_tx_empty(misc[15]), .i_b_tx_ready(misc[11]),
      .i_b_break_change(misc[14]), .o_rdata, .o_irq_n, .o_op_pins,
      .o_baud_set2, .o_timer_preload, .o_a_parity_mode, .o_a_parity_on,
      .o_a_multidrop, .o_a_parity_sense, .o_b_parity_mode, .o_b_parity_on,
      .o_b_multidrop, .o_b_parity_sense);
   task automatic chk(input string n, input [15:0] e, input [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Writes wait two extra cycles so pins and interrupt have settled.
   task automatic wr(input [3:0] a, input [7:0] v);
      @(negedge i_clk);
      {i_cs_n, i_wr_n, i_addr, i_wdata} = {2'b00, a, v};
      @(negedge i_clk);
      {i_cs_n, i_wr_n} = 2'b11;
      repeat (2) @(negedge i_clk);
   endtask
   task automatic rdc(input [3:0] a, input [7:0] e, input string n);
      @(negedge i_clk);
      {i_cs_n, i_rd_n, i_addr} = {2'b00, a};
      @(negedge i_clk);
      {i_cs_n, i_rd_n} = 2'b11;
      @(negedge i_clk);
      chk(n, e, o_rdata);
   endtask
   task automatic rx(input p, input [2:0] e);
      @(negedge i_clk);
      {push, pop, perr} = {p, !p, e};
      @(negedge i_clk);
      {push, pop} = 2'b00;
      repeat (4) @(negedge i_clk);
   endtask
   task automatic setm1(input [7:0] v);
      wr(4'h2, 8'h10);
      wr(4'h0, v);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // A hang counts as a mismatch; the tests need a few hundred cycles.
   initial begin
      #100000;
      error_cnt++;
      finish_test;
   end
   initial begin
      repeat (3) @(negedge i_clk);
      i_sys_rst = 1'b0;
      chk("pins", 16'h00FF, o_op_pins);
      chk("preload", 16'h0000, o_timer_preload);
      chk("parity", 16'h0004, {o_a_parity_mode, o_a_parity_on,
         o_a_multidrop, o_a_parity_sense});
      $display("reset test done");
      wr(4'hE, 8'hA5);
      chk("pins", 16'h005A, o_op_pins);
      wr(4'hF, 8'h85);
      chk("pins", 16'h00DF, o_op_pins);
      $display("strobe test done");
      wr(4'h4, 8'h80);
      chk("baud", 16'h0001, o_baud_set2);
      wr(4'h4, 8'h00);
      chk("baud", 16'h0000, o_baud_set2);
      wr(4'h6, 8'h12);
      wr(4'h7, 8'h34);
      chk("preload", 16'h1234, o_timer_preload);
      wr(4'hC, 8'h5A);
      rdc(4'hC, 8'h5A, "scratch");
      rdc(4'h3, 8'h00, "unmapped");
      $display("register test done");
      for (i = 0; i < 4; i++) begin
         setm1({3'h0, i[1:0], 3'h7});
         wr(4'hA, 8'h10);
         wr(4'h8, {3'h0, ~i[1:0], 3'h7});
         chk("parity", {i[1:0], i < 2, i == 3, i != 2}, {o_a_parity_mode,
            o_a_parity_on, o_a_multidrop, o_a_parity_sense});
         chk("parity b", {~i[1:0], i > 1, i == 0, i != 1}, {o_b_parity_mode,
            o_b_parity_on, o_b_multidrop, o_b_parity_sense});
      end
      wr(4'h0, 8'h77);
      wr(4'h2, 8'h10);
      rdc(4'h0, 8'h1F, "mode one");
      rdc(4'h0, 8'h77, "mode two");
      rdc(4'h0, 8'h77, "mode two");
      $display("mode test done");
      wr(4'h4, 8'h01);
      for (i = 0; i < 6; i++) begin
         misc = 16'h0001 << src[i];
         wr(4'h5, 8'h01 << bn[i]);
         chk("irq", 16'h0000, o_irq_n);
         rdc(4'h5, 8'h01 << bn[i], "irq status");
         wr(4'h5, 8'h00);
         chk("irq", 16'h0001, o_irq_n);
         misc = 16'h0000;
         wr(4'hA, 8'h50);
      end
      misc = 16'hAF00;
      wr(4'hD, 8'hE0);
      chk("pins", 16'h0001, o_op_pins[7:5]);
      rdc(4'h1, 8'h1C, "status a");
      rdc(4'h9, 8'h0E, "status b");
      misc = 16'h0000;
      rdc(4'h4, 8'h10, "input change");
      $display("interrupt test done");
      wr(4'h5, 8'h02);
      wr(4'hD, 8'h10);
      setm1(8'h13);
      rx(1'b1, 3'h1);
      rx(1'b1, 3'h0);
      chk("irq", 16'h0000, o_irq_n);
      chk("pin4", 16'h0000, o_op_pins[4]);
      rdc(4'h1, 8'h21, "status");
      rx(1'b0, 3'h0);
      rdc(4'h1, 8'h01, "status");
      rx(1'b0, 3'h0);
      setm1(8'h33);
      wr(4'h2, 8'h40);
      rx(1'b1, 3'h4);
      rx(1'b1, 3'h0);
      rdc(4'h1, 8'h81, "status");
      rx(1'b0, 3'h0);
      rdc(4'h1, 8'h81, "status");
      wr(4'h2, 8'h20);
      rdc(4'h1, 8'h01, "status");
      $display("error test done");
      setm1(8'h73);
      chk("irq", 16'h0001, o_irq_n);
      chk("pin4", 16'h0001, o_op_pins[4]);
      repeat (3) rx(1'b1, 3'h0);
      chk("irq", 16'h0000, o_irq_n);
      chk("pin4", 16'h0000, o_op_pins[4]);
      setm1(8'hF3);
      wr(4'hE, 8'h01);
      chk("pin0", 16'h0000, o_op_pins[0]);
      rx(1'b1, 3'h0);
      chk("pin0", 16'h0001, o_op_pins[0]);
      rx(1'b0, 3'h0);
      chk("pin0", 16'h0000, o_op_pins[0]);
      wr(4'hF, 8'h01);
      chk("pin0", 16'h0001, o_op_pins[0]);
      $display("flow test done");
      finish_test;
   end
endmodule

// >>> verilog/dmar_chan.v
// One channel: mode registers, pointer, error reporting and flow hold.
`include "dmar_defines.vh"
module dmar_chan (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_mode_wr,
   input wire i_mode_rd,
   input wire i_cmd_wr,
   input wire [7:0] i_wdata,
   input wire i_rx_ready,
   input wire i_fifo_full,
   input wire i_start_bit,
   input wire [2:0] i_top_err,
   input wire i_break_change,
   output reg [7:0] o_mode_one,
   output reg [7:0] o_mode_two,
   output reg o_mode_ptr,
   output reg [2:0] o_err_acc,
   output reg o_break_flag,
   output reg o_rts_hold,
   output wire [7:0] o_mode_rdata,
   output wire [2:0] o_err_status,
   output wire o_rx_int
);
   wire [2:0] cmd = i_wdata[`DMAR_CMD_HI:`DMAR_CMD_LO];
   wire cmd_ptr = i_cmd_wr && (cmd == `DMAR_CMD_SET_PTR);
   wire cmd_rx_rst = i_cmd_wr && (cmd == `DMAR_CMD_RX_RESET);
   wire cmd_err_rst = i_cmd_wr && (cmd == `DMAR_CMD_ERR_RESET);
   wire cmd_brk_rst = i_cmd_wr && (cmd == `DMAR_CMD_BRK_RESET);
   wire [2:0] top_now = i_rx_ready ? i_top_err : `DMAR_RST_ERR;

   // Mode data follows the pointer; the pointer moves after any mode one
   // access, and the set-pointer command brings it back.
   assign o_mode_rdata = o_mode_ptr ? o_mode_two : o_mode_one;
   // Character mode shows only the top character; block mode the OR.
   assign o_err_status = o_mode_one[`DMAR_M1_ERR_BLOCK] ?
      (o_err_acc | top_now) : top_now;
   assign o_rx_int = o_mode_one[`DMAR_M1_RX_INT_SEL] ?
      i_fifo_full : i_rx_ready;

   // Pointer and mode registers.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_mode_ptr <= 1'b0;
         o_mode_one <= `DMAR_RST_BYTE;
         o_mode_two <= `DMAR_RST_BYTE;
      end else begin
         if (i_mode_wr && !o_mode_ptr)
            o_mode_one <= i_wdata;
         if (i_mode_wr && o_mode_ptr)
            o_mode_two <= i_wdata;
         if (cmd_ptr)
            o_mode_ptr <= 1'b0;
         else if ((i_mode_wr || i_mode_rd) && !o_mode_ptr)
            o_mode_ptr <= 1'b1;
      end
   end

   // Error accumulation; a character arriving during a clear is kept.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_err_acc <= `DMAR_RST_ERR;
      end else begin
         o_err_acc <= ((cmd_err_rst || cmd_rx_rst) ? `DMAR_RST_ERR :
            o_err_acc) | top_now;
      end
   end

   // Break change flag is sticky until its reset command.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         o_break_flag <= 1'b0;
      else if (i_break_change)
         o_break_flag <= 1'b1;
      else if (cmd_brk_rst)
         o_break_flag <= 1'b0;
   end

   // Flow hold: a start bit against a full FIFO holds request-to-send off
   // until a FIFO position frees up. The latch bit itself is not touched.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         o_rts_hold <= 1'b0;
      else if (o_mode_one[`DMAR_M1_RX_FLOW] && i_start_bit && i_fifo_full)
         o_rts_hold <= 1'b1;
      else if (!i_fifo_full || !o_mode_one[`DMAR_M1_RX_FLOW] || cmd_rx_rst)
         o_rts_hold <= 1'b0;
   end
endmodule

// >>> verilog/dmar_defines.vh
// Register addresses, field positions, commands and reset values.
`ifndef DMAR_DEFINES_VH
`define DMAR_DEFINES_VH
// Register addresses on the 4-bit parallel bus.
`define DMAR_ADDR_A_MODE 4'h0
`define DMAR_ADDR_A_STATUS 4'h1
`define DMAR_ADDR_A_COMMAND 4'h2
`define DMAR_ADDR_INPUT_CHANGE 4'h4
`define DMAR_ADDR_IRQ 4'h5
`define DMAR_ADDR_PRELOAD_UPPER 4'h6
`define DMAR_ADDR_PRELOAD_LOWER 4'h7
`define DMAR_ADDR_B_MODE 4'h8
`define DMAR_ADDR_B_STATUS 4'h9
`define DMAR_ADDR_B_COMMAND 4'hA
`define DMAR_ADDR_SCRATCH 4'hC
`define DMAR_ADDR_PIN_CONFIG 4'hD
`define DMAR_ADDR_OUT_SET 4'hE
`define DMAR_ADDR_OUT_CLEAR 4'hF
// Mode register one fields.
`define DMAR_M1_RX_FLOW 7
`define DMAR_M1_RX_INT_SEL 6
`define DMAR_M1_ERR_BLOCK 5
`define DMAR_M1_PAR_HI 4
`define DMAR_M1_PAR_LO 3
`define DMAR_M1_PAR_TYPE 2
// Parity mode codes.
`define DMAR_PAR_WITH 2'h0
`define DMAR_PAR_FORCE 2'h1
`define DMAR_PAR_NONE 2'h2
`define DMAR_PAR_MULTIDROP 2'h3
// Miscellaneous command codes in command bits 6:4.
`define DMAR_CMD_HI 6
`define DMAR_CMD_LO 4
`define DMAR_CMD_SET_PTR 3'h1
`define DMAR_CMD_RX_RESET 3'h2
`define DMAR_CMD_ERR_RESET 3'h4
`define DMAR_CMD_BRK_RESET 3'h5
// Auxiliary control fields.
`define DMAR_AUX_BAUD_SET 7
// Pin configuration fields.
`define DMAR_CFG_OUT4 4
`define DMAR_CFG_OUT5 5
`define DMAR_CFG_OUT6 6
`define DMAR_CFG_OUT7 7
// Reset values.
`define DMAR_RST_BYTE 8'h00
`define DMAR_RST_NIBBLE 4'h0
`define DMAR_RST_ERR 3'h0
`endif

// >>> verilog/dmar_top.v
// Control and status registers of a dual asynchronous channel device.
`include "dmar_defines.vh"
module dmar_top (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_cs_n,
   input wire i_rd_n,
   input wire i_wr_n,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [6:0] i_ip,
   input wire i_counter_ready,
   input wire i_a_rx_ready,
   input wire i_a_fifo_full,
   input wire i_a_start_bit,
   input wire [2:0] i_a_top_err,
   input wire i_a_overrun,
   input wire i_a_tx_empty,
   input wire i_a_tx_ready,
   input wire i_a_break_change,
   input wire i_b_rx_ready,
   input wire i_b_fifo_full,
   input wire i_b_start_bit,
   input wire [2:0] i_b_top_err,
   input wire i_b_overrun,
   input wire i_b_tx_empty,
   input wire i_b_tx_ready,
   input wire i_b_break_change,
   output reg [7:0] o_rdata,
   output reg o_irq_n,
   output reg [7:0] o_op_pins,
   output reg o_baud_set2,
   output reg [15:0] o_timer_preload,
   output reg [1:0] o_a_parity_mode,
   output reg o_a_parity_on,
   output reg o_a_multidrop,
   output reg o_a_parity_sense,
   output reg [1:0] o_b_parity_mode,
   output reg o_b_parity_on,
   output reg o_b_multidrop,
   output reg o_b_parity_sense
);
   reg [7:0] aux_control;
   reg [7:0] irq_mask;
   reg [7:0] timer_preload_upper;
   reg [7:0] timer_preload_lower;
   reg [7:0] scratch;
   reg [7:0] output_latch;
   reg [7:0] output_pin_config;
   reg [3:0] ip_delta;
   reg [3:0] ip_prev;
   reg ip_primed;
   reg acc_busy;
   reg [7:0] next_rdata;
   reg [7:0] next_pins;
   wire [7:0] a_mode_one;
   wire [7:0] b_mode_one;
   wire [7:0] a_mode_rdata;
   wire [7:0] b_mode_rdata;
   wire [2:0] a_err;
   wire [2:0] b_err;
   wire a_rx_int;
   wire b_rx_int;
   wire a_hold;
   wire b_hold;
   wire a_brk;
   wire b_brk;
   wire [7:0] irq_status;

   // Parity is generated and checked in the with and force modes only.
   function dmar_par_on;
      input [1:0] mode;
      begin
         dmar_par_on = (mode == `DMAR_PAR_WITH) ||
            (mode == `DMAR_PAR_FORCE);
      end
   endfunction

   // One access per strobe: the first cycle of a low strobe is taken.
   wire rd_act = !i_cs_n && !i_rd_n;
   wire wr_act = !i_cs_n && !i_wr_n;
   wire rd_go = rd_act && !acc_busy;
   wire wr_go = wr_act && !acc_busy;

   // True for a taken access aimed at one register address.
   function dmar_hit;
      input go;
      input [3:0] addr;
      input [3:0] target;
      begin
         dmar_hit = go && (addr == target);
      end
   endfunction

   // Strobe history. A slow processor may hold a strobe for many clocks;
   // without this, one read of the input change register would clear
   // deltas on every edge and a held mode write would land in both.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         acc_busy <= 1'b0;
      else
         acc_busy <= rd_act || wr_act;
   end

   dmar_chan u_chan_a (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_mode_wr(dmar_hit(wr_go, i_addr, `DMAR_ADDR_A_MODE)),
      .i_mode_rd(dmar_hit(rd_go, i_addr, `DMAR_ADDR_A_MODE)),
      .i_cmd_wr(dmar_hit(wr_go, i_addr, `DMAR_ADDR_A_COMMAND)),
      .i_wdata(i_wdata),
      .i_rx_ready(i_a_rx_ready),
      .i_fifo_full(i_a_fifo_full),
      .i_start_bit(i_a_start_bit),
      .i_top_err(i_a_top_err),
      .i_break_change(i_a_break_change),
      .o_mode_one(a_mode_one),
      .o_mode_two(),
      .o_mode_ptr(),
      .o_err_acc(),
      .o_break_flag(a_brk),
      .o_rts_hold(a_hold),
      .o_mode_rdata(a_mode_rdata),
      .o_err_status(a_err),
      .o_rx_int(a_rx_int)
   );

   dmar_chan u_chan_b (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_mode_wr(dmar_hit(wr_go, i_addr, `DMAR_ADDR_B_MODE)),
      .i_mode_rd(dmar_hit(rd_go, i_addr, `DMAR_ADDR_B_MODE)),
      .i_cmd_wr(dmar_hit(wr_go, i_addr, `DMAR_ADDR_B_COMMAND)),
      .i_wdata(i_wdata),
      .i_rx_ready(i_b_rx_ready),
      .i_fifo_full(i_b_fifo_full),
      .i_start_bit(i_b_start_bit),
      .i_top_err(i_b_top_err),
      .i_break_change(i_b_break_change),
      .o_mode_one(b_mode_one),
      .o_mode_two(),
      .o_mode_ptr(),
      .o_err_acc(),
      .o_break_flag(b_brk),
      .o_rts_hold(b_hold),
      .o_mode_rdata(b_mode_rdata),
      .o_err_status(b_err),
      .o_rx_int(b_rx_int)
   );

   // Interrupt status: the input change bit honours the enables in the
   // auxiliary control register.
   assign irq_status = {|(ip_delta & aux_control[3:0]), b_brk, b_rx_int,
      i_b_tx_ready, i_counter_ready, a_brk, a_rx_int, i_a_tx_ready};

   // Writable registers.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aux_control <= `DMAR_RST_BYTE;
         irq_mask <= `DMAR_RST_BYTE;
         timer_preload_upper <= `DMAR_RST_BYTE;
         timer_preload_lower <= `DMAR_RST_BYTE;
         scratch <= `DMAR_RST_BYTE;
         output_pin_config <= `DMAR_RST_BYTE;
         output_latch <= `DMAR_RST_BYTE;
      end else begin
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_INPUT_CHANGE))
            aux_control <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_IRQ))
            irq_mask <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_PRELOAD_UPPER))
            timer_preload_upper <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_PRELOAD_LOWER))
            timer_preload_lower <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_SCRATCH))
            scratch <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_PIN_CONFIG))
            output_pin_config <= i_wdata;
         if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_OUT_SET))
            output_latch <= output_latch | i_wdata;
         else if (dmar_hit(wr_go, i_addr, `DMAR_ADDR_OUT_CLEAR))
            output_latch <= output_latch & ~i_wdata;
      end
   end

   // Input change detection. The first cycle after reset only primes
   // the history, so a non-zero input at reset is not a change.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ip_prev <= `DMAR_RST_NIBBLE;
         ip_primed <= 1'b0;
         ip_delta <= `DMAR_RST_NIBBLE;
      end else begin
         ip_prev <= i_ip[3:0];
         ip_primed <= 1'b1;
         // A change seen during the clearing read is kept.
         ip_delta <= (dmar_hit(rd_go, i_addr, `DMAR_ADDR_INPUT_CHANGE) ?
            `DMAR_RST_NIBBLE : ip_delta) |
            (ip_primed ? (i_ip[3:0] ^ ip_prev) : `DMAR_RST_NIBBLE);
      end
   end

   // Read multiplexer; unmapped and command-only addresses read zero.
   always @* begin
      next_rdata = o_rdata;
      if (rd_go) begin
         case (i_addr)
            `DMAR_ADDR_A_MODE: next_rdata = a_mode_rdata;
            `DMAR_ADDR_A_STATUS: next_rdata = {a_err, i_a_overrun,
               i_a_tx_empty, i_a_tx_ready, i_a_fifo_full, i_a_rx_ready};
            `DMAR_ADDR_INPUT_CHANGE: next_rdata = {ip_delta, i_ip[3:0]};
            `DMAR_ADDR_IRQ: next_rdata = irq_status;
            `DMAR_ADDR_PRELOAD_UPPER: next_rdata = timer_preload_upper;
            `DMAR_ADDR_PRELOAD_LOWER: next_rdata = timer_preload_lower;
            `DMAR_ADDR_B_MODE: next_rdata = b_mode_rdata;
            `DMAR_ADDR_B_STATUS: next_rdata = {b_err, i_b_overrun,
               i_b_tx_empty, i_b_tx_ready, i_b_fifo_full, i_b_rx_ready};
            `DMAR_ADDR_SCRATCH: next_rdata = scratch;
            `DMAR_ADDR_PIN_CONFIG: next_rdata = {1'b0, i_ip};
            default: next_rdata = `DMAR_RST_BYTE;
         endcase
      end
   end

   // Output pins are low for a latch one, except pins 4-7 when the pin configuration selects a status. Pins 0 and 1 are also forced
   // high by the receiver flow hold without touching the latch.
   always @* begin
      next_pins = ~output_latch;
      next_pins[0] = ~(output_latch[0] && !a_hold);
      next_pins[1] = ~(output_latch[1] && !b_hold);
      if (output_pin_config[`DMAR_CFG_OUT4])
         next_pins[4] = ~a_rx_int;
      if (output_pin_config[`DMAR_CFG_OUT5])
         next_pins[5] = ~b_rx_int;
      if (output_pin_config[`DMAR_CFG_OUT6])
         next_pins[6] = ~i_a_tx_ready;
      if (output_pin_config[`DMAR_CFG_OUT7])
         next_pins[7] = ~i_b_tx_ready;
   end

   // Registered outputs.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= `DMAR_RST_BYTE;
         o_irq_n <= 1'b1;
         o_op_pins <= ~`DMAR_RST_BYTE;
         o_baud_set2 <= 1'b0;
         o_timer_preload <= {`DMAR_RST_BYTE, `DMAR_RST_BYTE};
         o_a_parity_mode <= `DMAR_PAR_WITH;
         o_a_parity_on <= 1'b1;
         o_a_multidrop <= 1'b0;
         o_a_parity_sense <= 1'b0;
         o_b_parity_mode <= `DMAR_PAR_WITH;
         o_b_parity_on <= 1'b1;
         o_b_multidrop <= 1'b0;
         o_b_parity_sense <= 1'b0;
      end else begin
         o_rdata <= next_rdata;
         o_irq_n <= ~|(irq_status & irq_mask);
         o_op_pins <= next_pins;
         o_baud_set2 <= aux_control[`DMAR_AUX_BAUD_SET];
         o_timer_preload <= {timer_preload_upper,
            timer_preload_lower};
         o_a_parity_mode <= a_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO];
         o_a_parity_on <= dmar_par_on(
            a_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO]);
         o_a_multidrop <= (a_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO] ==
            `DMAR_PAR_MULTIDROP);
         // Sense bit is meaningless with no parity, so it is masked.
         o_a_parity_sense <= a_mode_one[`DMAR_M1_PAR_TYPE] &&
            (a_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO] !=
            `DMAR_PAR_NONE);
         o_b_parity_mode <= b_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO];
         o_b_parity_on <= dmar_par_on(
            b_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO]);
         o_b_multidrop <= (b_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO] ==
            `DMAR_PAR_MULTIDROP);
         o_b_parity_sense <= b_mode_one[`DMAR_M1_PAR_TYPE] &&
            (b_mode_one[`DMAR_M1_PAR_HI:`DMAR_M1_PAR_LO] !=
            `DMAR_PAR_NONE);
      end
   end
endmodule
